// ===== core/dac_aux_cal_config_regs.sv
// Module: aux converter, reference and calibration register group with Wishbone slave
//
// Design decision made here: the Wishbone register port.
module dac_aux_cal_config_regs
  import aux_cal_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Analog control outputs
  output logic [9:0] auxWordFirst,
  output logic [9:0] auxWordSecond,
  output logic auxOutEnableFirst,
  output logic auxOutEnableSecond,
  output logic [1:0] auxSpanFirst,
  output logic [1:0] auxSpanSecond,
  output logic [2:0] auxTopFirst,
  output logic [2:0] auxTopSecond,
  output logic [5:0] referenceTrimCode,
  // Calibration engine view
  output logic calClockTick,
  output logic calBusy,
  output logic [5:0] preloadFirst,
  output logic [5:0] preloadSecond,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] auxLowFirst_q;
  logic [7:0] auxCtlFirst_q;
  logic [7:0] auxLowSecond_q;
  logic [7:0] auxCtlSecond_q;
  logic [7:0] refTrim_q;
  logic [7:0] calCtl_q;
  logic [5:0] userPreload_q;
  logic calDoneFirst_q;
  logic calDoneSecond_q;
  logic [1:0] irqStatus_q;
  logic [1:0] irqEnable_q;
  logic [7:0] divCount_q;
  logic [7:0] calTicks_q;
  logic runFirst_q;
  logic runSecond_q;
  cal_state_type calState_q;
  logic ack_q;
  logic [31:0] rdata_q;

  logic [7:0] regIdx;
  logic [7:0] wByte;
  logic wrEn;
  logic rdEn;
  logic startPulse;
  logic calFinish;
  logic [7:0] divLimit;
  logic tick;
  logic [7:0] rdMux;
  logic [1:0] doneEvent;
  logic [1:0] clearHit;

  assign regIdx = adr_i[9:2];
  assign wByte = dat_i[7:0];
  // One request per bus cycle: ack answers one cycle after stb, then drops
  assign wrEn = cyc_i && stb_i && we_i && !ack_q && sel_i[0];
  assign rdEn = cyc_i && stb_i && !we_i && !ack_q;
  assign ack_o = ack_q;
  assign dat_o = rdata_q;

  // ----------------------------------------
  // Bus handshake and read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  always_comb
  begin
    case (regIdx)
      IDX_AUX_LOW_FIRST: rdMux = auxLowFirst_q;
      IDX_AUX_CTL_FIRST: rdMux = auxCtlFirst_q;
      IDX_AUX_LOW_SECOND: rdMux = auxLowSecond_q;
      IDX_AUX_CTL_SECOND: rdMux = auxCtlSecond_q;
      IDX_REF_TRIM: rdMux = refTrim_q;
      IDX_CAL_CTL: rdMux = calCtl_q;
      // Done bits and nothing else; other status bits read zero
      IDX_CAL_STATUS: rdMux = {calDoneSecond_q, calDoneFirst_q, 6'h00};
      IDX_IRQ_STATUS: rdMux = {6'h00, irqStatus_q};
      IDX_IRQ_ENABLE: rdMux = {6'h00, irqEnable_q};
      IDX_USER_PRELOAD: rdMux = {2'b00, userPreload_q};
      // Unmapped and write-only locations read zero
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (rdEn)
    begin
      rdata_q <= {24'h00_0000, rdMux};
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auxLowFirst_q <= AUX_LOW_RESET;
      auxCtlFirst_q <= AUX_CTL_RESET;
      auxLowSecond_q <= AUX_LOW_RESET;
      auxCtlSecond_q <= AUX_CTL_RESET;
    end
    else if (wrEn)
    begin
      case (regIdx)
        IDX_AUX_LOW_FIRST: auxLowFirst_q <= wByte;
        IDX_AUX_CTL_FIRST: auxCtlFirst_q <= wByte & AUX_CTL_MASK;
        IDX_AUX_LOW_SECOND: auxLowSecond_q <= wByte;
        IDX_AUX_CTL_SECOND: auxCtlSecond_q <= wByte & AUX_CTL_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refTrim_q <= REF_TRIM_RESET;
      calCtl_q <= CAL_CTL_RESET;
      userPreload_q <= USER_PRELOAD_RESET;
      irqEnable_q <= 2'b00;
    end
    else if (wrEn)
    begin
      case (regIdx)
        IDX_REF_TRIM: refTrim_q <= wByte & REF_TRIM_MASK;
        IDX_CAL_CTL: calCtl_q <= wByte;
        IDX_IRQ_ENABLE: irqEnable_q <= wByte[1:0];
        IDX_USER_PRELOAD: userPreload_q <= wByte[5:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Analog control fields
  // ----------------------------------------
  // Fields lag their register by one edge; a word split over two registers changes one register write at a time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auxWordFirst <= 10'h000;
      auxOutEnableFirst <= 1'b0;
      auxSpanFirst <= 2'b00;
      auxTopFirst <= 3'b000;
    end
    else
    begin
      auxWordFirst <= {auxCtlFirst_q[1:0], auxLowFirst_q};
      auxOutEnableFirst <= auxCtlFirst_q[AUX_EN_BIT];
      auxSpanFirst <= auxCtlFirst_q[AUX_SPAN_LSB +: 2];
      auxTopFirst <= auxCtlFirst_q[AUX_TOP_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auxWordSecond <= 10'h000;
      auxOutEnableSecond <= 1'b0;
      auxSpanSecond <= 2'b00;
      auxTopSecond <= 3'b000;
    end
    else
    begin
      auxWordSecond <= {auxCtlSecond_q[1:0], auxLowSecond_q};
      auxOutEnableSecond <= auxCtlSecond_q[AUX_EN_BIT];
      auxSpanSecond <= auxCtlSecond_q[AUX_SPAN_LSB +: 2];
      auxTopSecond <= auxCtlSecond_q[AUX_TOP_LSB +: 3];
    end
  end

  // ----------------------------------------
  // Reference trim and calibration preloads
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      referenceTrimCode <= 6'h00;
    end
    else
    begin
      referenceTrimCode <= refTrim_q[5:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      preloadFirst <= FIXED_PRELOAD;
      preloadSecond <= FIXED_PRELOAD;
    end
    else
    begin
      preloadFirst <= calCtl_q[PRELOAD_FIRST_BIT] ? userPreload_q : FIXED_PRELOAD;
      preloadSecond <= calCtl_q[PRELOAD_SECOND_BIT] ? userPreload_q : FIXED_PRELOAD;
    end
  end

  // ----------------------------------------
  // Calibration clock divider
  // ----------------------------------------
  // Unlisted divider codes fall back to divide by 256 as the safest slow rate
  always_comb
  begin
    case (calCtl_q[2:0])
      3'b001: divLimit = DIV_LIMIT_128;
      3'b110: divLimit = DIV_LIMIT_4;
      3'b111: divLimit = DIV_LIMIT_2;
      default: divLimit = DIV_LIMIT_256;
    endcase
  end

  assign tick = calCtl_q[CLK_GATE_BIT] && (divCount_q >= divLimit);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCount_q <= 8'h00;
    end
    else if (!calCtl_q[CLK_GATE_BIT] || tick)
    begin
      divCount_q <= 8'h00;
    end
    else
    begin
      divCount_q <= divCount_q + 8'h01;
    end
  end

  assign calClockTick = tick;

  // ----------------------------------------
  // Self-calibration sequencer
  // ----------------------------------------
  assign startPulse = wrEn && (regIdx == IDX_MEM_CTL) && wByte[START_BIT];
  // Without a running calibration clock a started run stalls until it is enabled
  assign calFinish = (calState_q == CAL_RUN) && tick && (calTicks_q == CAL_TICKS - 8'h01);
  assign calBusy = (calState_q == CAL_RUN);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      calState_q <= CAL_IDLE;
      calTicks_q <= 8'h00;
      runFirst_q <= 1'b0;
      runSecond_q <= 1'b0;
    end
    else
    begin
      case (calState_q)
        CAL_IDLE:
        begin
          if (startPulse && (calCtl_q[PICK_FIRST_BIT] || calCtl_q[PICK_SECOND_BIT]))
          begin
            calState_q <= CAL_RUN;
            calTicks_q <= 8'h00;
            runFirst_q <= calCtl_q[PICK_FIRST_BIT];
            runSecond_q <= calCtl_q[PICK_SECOND_BIT];
          end
        end
        CAL_RUN:
        begin
          if (calFinish)
          begin
            calState_q <= CAL_IDLE;
          end
          else if (tick)
          begin
            calTicks_q <= calTicks_q + 8'h01;
          end
        end
        default: calState_q <= CAL_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Completion flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      calDoneFirst_q <= 1'b0;
      calDoneSecond_q <= 1'b0;
    end
    else
    begin
      if (calFinish && runFirst_q)
      begin
        calDoneFirst_q <= 1'b1;
      end
      else if (startPulse && calState_q == CAL_IDLE && calCtl_q[PICK_FIRST_BIT])
      begin
        calDoneFirst_q <= 1'b0;
      end
      if (calFinish && runSecond_q)
      begin
        calDoneSecond_q <= 1'b1;
      end
      else if (startPulse && calState_q == CAL_IDLE && calCtl_q[PICK_SECOND_BIT])
      begin
        calDoneSecond_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupts: bit 0 first done, bit 1 second done
  // ----------------------------------------
  // Set beats clear so a completion in the clearing cycle is kept
  assign doneEvent = {calFinish && runSecond_q, calFinish && runFirst_q};
  assign clearHit = (wrEn && regIdx == IDX_IRQ_CLEAR) ? wByte[1:0] : 2'b00;

  for (genvar i = 0; i < 2; i++)
  begin : g_irq
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        irqStatus_q[i] <= 1'b0;
      end
      else if (doneEvent[i])
      begin
        irqStatus_q[i] <= 1'b1;
      end
      else if (clearHit[i])
      begin
        irqStatus_q[i] <= 1'b0;
      end
    end
  end

  assign irq = |(irqStatus_q & irqEnable_q);

endmodule : dac_aux_cal_config_regs

// ===== core/aux_cal_pkg.sv
// Package: register map, field layout, reset values and timing for the aux/cal register group
//
// Contract
// - Second aux word is low byte at 0x0B plus bits 1:0 at 0x0C.
// - First aux word upper bits sit in its control bits 1:0, low byte 0x09.
// - Aux code 0x3FF full, 0x200 mid, 0x000 bottom; reset 0x000.
// - Second control bit 7 enables the second aux output; default off.
// - Range field bits 6:5 pick 2, 1.5, 1.0 or 0.5 V span.
// - Top field bits 4:2 pick 1.0 to 2.9 V; default 1.0 V.
// - First channel top field uses the same encoding.
// - Reference trim 0x0D bits 5:0 is two's complement; default zero.
// - Control bit 7 picks fixed 32 or user value for second preload.
// - Control bit 6 makes the same preload choice for the first channel.
// - Control bits 5 and 4 select second and first channel self-calibration.
// - Control bit 3 gates the calibration clock; default stopped.
// - Bits 2:0 divide converter clock by 256, 128, ... 4, 2; codes 010 to 101 divide by 256 here.
// - Status 0x0F bit 7 is 0 while second calibrates, 1 when done.
// - Writing 1 to memory control bit 4 starts self-calibration; 0 does nothing.
// - Status bit 6 is 1 once first channel calibration completes.
package aux_cal_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_AUX_LOW_FIRST = 8'h09;
  localparam logic [7:0] IDX_AUX_CTL_FIRST = 8'h0A;
  localparam logic [7:0] IDX_AUX_LOW_SECOND = 8'h0B;
  localparam logic [7:0] IDX_AUX_CTL_SECOND = 8'h0C;
  localparam logic [7:0] IDX_REF_TRIM = 8'h0D;
  localparam logic [7:0] IDX_CAL_CTL = 8'h0E;
  localparam logic [7:0] IDX_CAL_STATUS = 8'h0F;
  localparam logic [7:0] IDX_MEM_CTL = 8'h12;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h21;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h22;
  localparam logic [7:0] IDX_USER_PRELOAD = 8'h23;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int AUX_EN_BIT = 7;
  localparam int AUX_SPAN_LSB = 5;
  localparam int AUX_TOP_LSB = 2;
  localparam int PRELOAD_SECOND_BIT = 7;
  localparam int PRELOAD_FIRST_BIT = 6;
  localparam int PICK_SECOND_BIT = 5;
  localparam int PICK_FIRST_BIT = 4;
  localparam int CLK_GATE_BIT = 3;
  localparam int DONE_SECOND_BIT = 7;
  localparam int DONE_FIRST_BIT = 6;
  localparam int START_BIT = 4;

  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [7:0] AUX_CTL_MASK = 8'hFF;
  localparam logic [7:0] REF_TRIM_MASK = 8'h3F;
  localparam logic [7:0] AUX_LOW_RESET = 8'h00;
  localparam logic [7:0] AUX_CTL_RESET = 8'h00;
  localparam logic [7:0] REF_TRIM_RESET = 8'h00;
  localparam logic [7:0] CAL_CTL_RESET = 8'h00;
  localparam logic [5:0] FIXED_PRELOAD = 6'h20;
  localparam logic [5:0] USER_PRELOAD_RESET = 6'h00;

  // ----------------------------------------
  // Calibration timing: cycles of the calibration clock per run
  // ----------------------------------------
  localparam logic [7:0] CAL_TICKS = 8'h40;
  // Divider terminal counts: the count runs from zero to the limit inclusive
  localparam logic [7:0] DIV_LIMIT_256 = 8'hFF;
  localparam logic [7:0] DIV_LIMIT_128 = 8'h7F;
  localparam logic [7:0] DIV_LIMIT_4 = 8'h03;
  localparam logic [7:0] DIV_LIMIT_2 = 8'h01;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01
  } cal_state_type;

endpackage : aux_cal_pkg

// ===== testbench/dac_aux_cal_config_regs_checker.sv
// Checker: port-level assertions for the aux/cal register group
module dac_aux_cal_config_regs_checker
  import aux_cal_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Field outputs
  input wire logic [9:0] auxWordFirst,
  input wire logic [9:0] auxWordSecond,
  input wire logic auxOutEnableSecond,
  input wire logic [1:0] auxSpanSecond,
  input wire logic [2:0] auxTopSecond,
  input wire logic [5:0] referenceTrimCode,
  input wire logic [5:0] preloadSecond
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Write seen at the ack edge; master still holds the request there
  // ----------------------------------------
  sequence s_wr(logic [7:0] idx);
    ack_o && we_i && sel_i[0] && adr_i[9:2] == idx;
  endsequence
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_reset_defaults: assert property ($rose(rst_n) |-> auxWordFirst == 10'h000
    && auxWordSecond == 10'h000 && referenceTrimCode == 6'h00 && preloadSecond == 6'h20)
    else $error("outputs not at defaults after reset");
  a_word_first: assert property (s_wr(8'h09) |=> auxWordFirst[7:0] == $past(dat_i[7:0]))
    else $error("first aux low byte not applied");
  a_word_second: assert property (s_wr(8'h0B) |=> auxWordSecond[7:0] == $past(dat_i[7:0]))
    else $error("second aux low byte not applied");
  a_ctl_second: assert property (s_wr(8'h0C) |=> auxWordSecond[9:8] == $past(dat_i[1:0])
    && auxOutEnableSecond == $past(dat_i[7]) && auxSpanSecond == $past(dat_i[6:5])
    && auxTopSecond == $past(dat_i[4:2]))
    else $error("second aux control fields not applied");
  a_trim_field: assert property (s_wr(8'h0D) |=> referenceTrimCode == $past(dat_i[5:0]))
    else $error("reference trim not applied");
  a_preload_fixed: assert property (s_wr(8'h0E) && !dat_i[7] |-> ##[1:2] preloadSecond == 6'h20)
    else $error("fixed preload not selected");
  a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
endmodule : dac_aux_cal_config_regs_checker

bind dac_aux_cal_config_regs dac_aux_cal_config_regs_checker u_dac_aux_cal_config_regs_checker (
  .clk(clk), .rst_n(rst_n), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .auxWordFirst(auxWordFirst), .auxWordSecond(auxWordSecond),
  .auxOutEnableSecond(auxOutEnableSecond), .auxSpanSecond(auxSpanSecond),
  .auxTopSecond(auxTopSecond), .referenceTrimCode(referenceTrimCode),
  .preloadSecond(preloadSecond));

// ===== testbench/dac_aux_cal_config_regs_tb.sv
// Testbench: register access, aux fields, calibration and interrupt scenarios
module dac_aux_cal_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, cycI = 0, stbI = 0, weI = 0;
  logic [9:0] adrI = 10'h000;
  logic [3:0] selI = 4'h0;
  logic [31:0] datI = 32'h0000_0000, dat_o, rdData;
  logic ack_o, auxOutEnableFirst, auxOutEnableSecond, calClockTick, calBusy, irq;
  logic [9:0] auxWordFirst, auxWordSecond;
  logic [1:0] auxSpanFirst, auxSpanSecond;
  logic [2:0] auxTopFirst, auxTopSecond;
  logic [5:0] referenceTrimCode, preloadFirst, preloadSecond;
  int err_count = 0, checks = 0;
  always #12.5 clk = ~clk;
  dac_aux_cal_config_regs u_dac_aux_cal_config_regs (.clk(clk), .rst_n(rst_n), .cyc_i(cycI),
    .stb_i(stbI), .we_i(weI), .adr_i(adrI), .sel_i(selI), .dat_i(datI), .dat_o(dat_o),
    .ack_o(ack_o), .auxWordFirst(auxWordFirst), .auxWordSecond(auxWordSecond),
    .auxOutEnableFirst(auxOutEnableFirst), .auxOutEnableSecond(auxOutEnableSecond),
    .auxSpanFirst(auxSpanFirst), .auxSpanSecond(auxSpanSecond), .auxTopFirst(auxTopFirst),
    .auxTopSecond(auxTopSecond), .referenceTrimCode(referenceTrimCode),
    .calClockTick(calClockTick), .calBusy(calBusy), .preloadFirst(preloadFirst),
    .preloadSecond(preloadSecond), .irq(irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("Checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Classic cycle; ack seen just after an edge is taken at the following edge
  task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic s);
    int n;
    @(posedge clk);
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI <= wr;
    adrI <= {idx, 2'b00};
    selI <= {3'b000, s};
    datI <= {24'h00_0000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_count++;
      wrap_up();
    end
    @(posedge clk);
    rdData = dat_o;
    cycI <= 1'b0;
    stbI <= 1'b0;
    @(posedge clk);
    #1;
  endtask : wb
  task automatic ticks(input logic [7:0] ctl, input int len, input int exp);
    int c;
    wb(1, 8'h0E, ctl, 1);
    c = 0;
    repeat (len)
    begin
      @(posedge clk);
      #1;
      if (calClockTick === 1'b1)
        c++;
    end
    check("tick count", c, exp);
  endtask : ticks
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 9; i < 16; i++)
    begin
      wb(0, i[7:0], 8'h00, 1);
      check("reset value", rdData, 32'h0000_0000);
    end
    check("preload first", preloadFirst, 6'h20);
    wb(1, 8'h0F, 8'hFF, 1);
    wb(0, 8'h0F, 8'h00, 1);
    check("status write", rdData, 32'h0000_0000);
    wb(0, 8'h30, 8'h00, 1);
    check("unmapped read", rdData, 32'h0000_0000);
  endtask : t_reset
  task automatic t_aux;
    logic [7:0] v;
    wb(1, 8'h0B, 8'hFF, 1);
    wb(1, 8'h0C, 8'h03, 1);
    check("word second", auxWordSecond, 10'h3FF);
    wb(1, 8'h09, 8'h00, 1);
    wb(1, 8'h0A, 8'h02, 1);
    check("word first", auxWordFirst, 10'h200);
    for (int i = 0; i < 5; i++)
    begin
      v = {1'b1, i[1:0], i[2:0], 2'b00};
      wb(1, 8'h0C, v, 1);
      wb(1, 8'h0A, v, 1);
      check("enable second", auxOutEnableSecond, 1'b1);
      check("span second", auxSpanSecond, i[1:0]);
      check("top second", auxTopSecond, i[2:0]);
      check("top first", auxTopFirst, i[2:0]);
      check("enable first", auxOutEnableFirst, 1'b1);
      check("span first", auxSpanFirst, i[1:0]);
    end
    wb(1, 8'h0C, 8'h00, 0);
    check("no byte lane", auxOutEnableSecond, 1'b1);
    wb(1, 8'h0C, 8'h00, 1);
    check("disable second", auxOutEnableSecond, 1'b0);
  endtask : t_aux
  task automatic t_trim;
    wb(1, 8'h0D, 8'hFF, 1);
    wb(0, 8'h0D, 8'h00, 1);
    check("trim readback", rdData, 32'h0000_003F);
    wb(1, 8'h0D, 8'h20, 1);
    check("trim code", referenceTrimCode, 6'h20);
  endtask : t_trim
  task automatic t_cal;
    int n;
    wb(1, 8'h23, 8'h15, 1);
    ticks(8'h07, 40, 0);
    ticks(8'h0F, 40, 20);
    ticks(8'h0E, 40, 10);
    ticks(8'h09, 256, 2);
    ticks(8'h08, 512, 2);
    wb(1, 8'h0E, 8'hFF, 1);
    check("user preload", {preloadFirst, preloadSecond}, 12'h555);
    wb(1, 8'h21, 8'h03, 1);
    wb(1, 8'h12, 8'h00, 1);
    check("no start", calBusy, 1'b0);
    wb(1, 8'h12, 8'h10, 1);
    check("start", calBusy, 1'b1);
    wb(0, 8'h0F, 8'h00, 1);
    check("in progress", rdData, 32'h0000_0000);
    n = 0;
    while (calBusy !== 1'b0 && n < 1000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 1000)
    begin
      err_count++;
      wrap_up();
    end
    wb(0, 8'h0F, 8'h00, 1);
    check("done bits", rdData, 32'h0000_00C0);
    check("irq raised", irq, 1'b1);
    wb(1, 8'h21, 8'h00, 1);
    check("irq masked", irq, 1'b0);
    wb(1, 8'h21, 8'h03, 1);
    wb(1, 8'h22, 8'h03, 1);
    check("irq cleared", irq, 1'b0);
    wb(0, 8'h20, 8'h00, 1);
    check("irq status", rdData, 32'h0000_0000);
    wb(1, 8'h0E, 8'h00, 1);
    check("fixed preload", {preloadFirst, preloadSecond}, 12'h820);
  endtask : t_cal
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_aux();
    t_trim();
    t_cal();
    wrap_up();
  end
endmodule : dac_aux_cal_config_regs_tb
